// ### common/adc_ctrl_defs.svh
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// control word layout, first bit shifted is bit 11
`define CW_WIDTH 12
`define CW_WRITE 11
`define CW_SEQ_HI 10
`define CW_IGN_HI 9
`define CW_IGN_MID 8
`define CW_ADDR_HI 7
`define CW_ADDR_LO 6
`define CW_PM_HI 5
`define CW_PM_LO 4
`define CW_SEQ_LO 3
`define CW_IGN_LO 2
`define CW_SPAN 1
`define CW_CODING 0

// power mode encodings
`define PM_NORMAL 2'h3
`define PM_SHUTDOWN 2'h2
`define PM_AUTO 2'h1

// reset contents: normal power, no sequencer, channel 0
`define CFG_RESET_PM 2'h3

// transfer framing in serial clock falling edges
`define XFER_EDGES 16
`define LOAD_EDGE 12
`define MUX_EDGE 14
`define RESULT_BITS 12

// wake-up time from full shutdown
`define CLK_MHZ 25
`define WAKE_NS 1000
`define WAKE_CYCLES ((`WAKE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### common/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

   typedef enum logic [1:0] {
      PWR_ON,
      PWR_WAKING,
      PWR_OFF
   } power_e;

   typedef struct packed {
      logic seq_hi;
      logic [1:0] addr;
      logic [1:0] pm;
      logic seq_lo;
      logic span;
      logic coding;
   } config_s;

endpackage

// ### common/serial_pins_if.sv
`timescale 1ns/1ns
interface serial_pins_if;
   logic cs_active;
   logic cs_fall;
   logic sclk_fall;
   logic din;

   modport front (
      output cs_active,
      output cs_fall,
      output sclk_fall,
      output din
   );

   modport core (
      input cs_active,
      input cs_fall,
      input sclk_fall,
      input din
   );
endinterface

// ### verilog/serial_pin_sync.sv
`timescale 1ns/1ns
module serial_pin_sync (
   input wire logic clk, // system clock
   input wire logic rst_n, // synchronised reset, low active
   input wire logic cs_b_pin, // chip select pin
   input wire logic sclk_pin, // serial clock pin
   input wire logic din_pin, // serial data pin
   serial_pins_if.front sif // conditioned pin events
);
   // bit order in all vectors: {cs_b, sclk, din}
   logic [2:0] s1_r;
   logic [2:0] s1_nxt;
   logic [2:0] s2_r;
   logic [2:0] s2_nxt;
   logic [1:0] d_r;
   logic [1:0] d_nxt;

   always_comb begin
      s1_nxt = {cs_b_pin, sclk_pin, din_pin};
      s2_nxt = s1_r;
      d_nxt = s2_r[2:1];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 3'h6;
         s2_r <= 3'h6;
         d_r <= 2'h3;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         d_r <= d_nxt;
      end
   end

   // edges only from second and third stages
   assign sif.cs_active = ~s2_r[2];
   assign sif.cs_fall = d_r[1] & ~s2_r[2];
   assign sif.sclk_fall = d_r[0] & ~s2_r[1] & ~s2_r[2];
   assign sif.din = s2_r[0];
endmodule

// ### verilog/adc_control_word_decoder.sv
`timescale 1ns/1ns
`include "adc_ctrl_defs.svh"
// What this block does
// [RULE1] first bit 1 loads the other eleven bits; 0 leaves the register alone
// [RULE2] bit 10 and bit 3 together pick the sequencer behaviour
// [RULE3] address bits 7:6 are taken on the 14th falling edge for the next channel
// [RULE4] two channel bits go out on the data line before the result
// [RULE5] input mux moves to the next channel on the 14th falling edge
// [RULE6] power bits 11 keep the device fully powered
// [RULE7] power bits 10 shut everything down until those bits change
// [RULE8] configuration survives full shutdown untouched
// [RULE9] power bits 01 shut down after each conversion that wrote the register
// [RULE10] waking takes one microsecond; host waits before a valid conversion
// [RULE11] host never writes power bits 00
// [RULE12] span bit 0 gives twice reference, 1 gives reference, next conversion
// [RULE13] coding bit 0 gives twos complement, 1 straight binary, next conversion
// [RULE14] only the first twelve falling edges after select are loaded, MSB first
// [RULE15] host gives sixteen serial clocks per transfer
// [RULE16] both sequencer bits 1 run channels 0 up to the address, repeating
// [RULE17] bits 9, 8 and 2 are accepted and ignored
module adc_control_word_decoder #(
   parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES
) (
   input wire logic CLK, // 25 MHz system clock
   input wire logic RST_B, // reset, low active, asynchronous
   input wire logic CS_B, // chip select pin, low active
   input wire logic SCLK, // serial clock pin, well below CLK/4
   input wire logic DIN, // serial data in pin
   input wire logic [11:0] CONV_RESULT, // straight binary from converter core
   output logic DOUT, // serial data out
   output logic DOUT_OE, // drive enable for DOUT
   output logic [1:0] MUX_CHANNEL, // channel routed to the sampler
   output logic SPAN_REF_ONLY, // 1: span 0..ref, 0: 0..2*ref
   output logic CODING_BINARY, // 1: straight binary, 0: twos complement
   output logic POWER_ON, // analog circuitry powered and settled
   output logic WAKE_BUSY, // wake-up interval running
   output logic SEQ_ACTIVE // consecutive channel sequence running
);
   localparam int WAKE_M1 = WAKE_CYCLES - 1;
   localparam int WW = $clog2(WAKE_CYCLES + 1);

   function automatic adc_ctrl_pkg::config_s decode_word(input logic [11:0] w);
      adc_ctrl_pkg::config_s c;
      c.seq_hi = w[`CW_SEQ_HI];
      c.addr = w[`CW_ADDR_HI:`CW_ADDR_LO];
      c.pm = w[`CW_PM_HI:`CW_PM_LO];
      c.seq_lo = w[`CW_SEQ_LO];
      c.span = w[`CW_SPAN];
      c.coding = w[`CW_CODING];
      return c;
   endfunction

   function automatic logic [11:0] apply_coding(input logic [11:0] r,
                                                input logic binary);
      return binary ? r : {~r[11], r[10:0]};
   endfunction

   // reset release
   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   serial_pins_if sif ();

   serial_pin_sync u_sync (
      .clk(CLK),
      .rst_n(rst_n),
      .cs_b_pin(CS_B),
      .sclk_pin(SCLK),
      .din_pin(DIN),
      .sif(sif)
   );

   // transfer and configuration state
   adc_ctrl_pkg::config_s cfg_r;
   adc_ctrl_pkg::config_s cfg_nxt;
   logic [10:0] rx_r;
   logic [10:0] rx_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic wrote_r;
   logic wrote_nxt;
   logic [15:0] tx_r;
   logic [15:0] tx_nxt;
   logic [1:0] ch_r;
   logic [1:0] ch_nxt;
   logic seq_run_r;
   logic seq_run_nxt;
   logic [1:0] seq_last_r;
   logic [1:0] seq_last_nxt;
   logic span_act_r;
   logic span_act_nxt;
   logic coding_act_r;
   logic coding_act_nxt;
   logic [11:0] word;
   logic edge_ok;
   logic ld_edge;
   logic mux_edge;
   logic conv_end;

   assign word = {rx_r, sif.din};
   assign edge_ok = sif.sclk_fall && sif.cs_active && (cnt_r < 5'(`XFER_EDGES));
   assign ld_edge = edge_ok && (cnt_r == 5'(`LOAD_EDGE - 1));
   assign mux_edge = edge_ok && (cnt_r == 5'(`MUX_EDGE - 1));
   assign conv_end = edge_ok && (cnt_r == 5'(`XFER_EDGES - 1));

   always_comb begin
      cfg_nxt = cfg_r; // RULE8
      rx_nxt = rx_r;
      cnt_nxt = cnt_r;
      wrote_nxt = wrote_r;
      tx_nxt = tx_r;
      ch_nxt = ch_r;
      seq_run_nxt = seq_run_r;
      seq_last_nxt = seq_last_r;
      span_act_nxt = span_act_r;
      coding_act_nxt = coding_act_r;
      if (sif.cs_fall) begin
         cnt_nxt = 5'h00;
         wrote_nxt = 1'b0;
         // settings written earlier apply to this conversion
         span_act_nxt = cfg_r.span; // RULE12
         coding_act_nxt = cfg_r.coding; // RULE13
         tx_nxt = {ch_r, apply_coding(CONV_RESULT, cfg_r.coding), 2'h0}; // RULE4
      end else if (edge_ok) begin
         cnt_nxt = 5'(cnt_r + 5'h01);
         tx_nxt = {tx_r[14:0], 1'b0}; // RULE4
         if (cnt_r < 5'(`LOAD_EDGE)) begin
            rx_nxt = word[10:0]; // RULE14
         end
         if (ld_edge && word[`CW_WRITE]) begin
            cfg_nxt = decode_word(word); // RULE1 RULE17
            wrote_nxt = 1'b1;
         end
         if (mux_edge) begin
            if (wrote_r && cfg_r.seq_hi && cfg_r.seq_lo) begin
               seq_run_nxt = 1'b1; // RULE16
               seq_last_nxt = cfg_r.addr; // RULE3
               ch_nxt = 2'h0; // RULE5
            end else if (wrote_r && !cfg_r.seq_hi) begin
               seq_run_nxt = 1'b0; // RULE2
               ch_nxt = cfg_r.addr; // RULE3 RULE5
            end else if (seq_run_r) begin
               // sequence keeps running with 10 written
               ch_nxt = (ch_r == seq_last_r) ? 2'h0 : 2'(ch_r + 2'h1); // RULE16 RULE2
            end else begin
               ch_nxt = cfg_r.addr; // RULE3
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= '{seq_hi: 1'b0, addr: 2'h0, pm: `CFG_RESET_PM, seq_lo: 1'b0,
                    span: 1'b0, coding: 1'b0};
         rx_r <= 11'h000;
         cnt_r <= 5'(`XFER_EDGES);
         wrote_r <= 1'b0;
         tx_r <= 16'h0000;
         ch_r <= 2'h0;
         seq_run_r <= 1'b0;
         seq_last_r <= 2'h0;
         span_act_r <= 1'b0;
         coding_act_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         rx_r <= rx_nxt;
         cnt_r <= cnt_nxt;
         wrote_r <= wrote_nxt;
         tx_r <= tx_nxt;
         ch_r <= ch_nxt;
         seq_run_r <= seq_run_nxt;
         seq_last_r <= seq_last_nxt;
         span_act_r <= span_act_nxt;
         coding_act_r <= coding_act_nxt;
      end
   end

   // power management
   adc_ctrl_pkg::power_e pwr_r;
   adc_ctrl_pkg::power_e pwr_nxt;
   logic [WW-1:0] wake_r;
   logic [WW-1:0] wake_nxt;

   always_comb begin
      pwr_nxt = pwr_r;
      wake_nxt = wake_r;
      case (pwr_r)
         adc_ctrl_pkg::PWR_ON: begin
            // normal mode never leaves this state
            if (conv_end && cfg_r.pm == `PM_SHUTDOWN) begin
               pwr_nxt = adc_ctrl_pkg::PWR_OFF; // RULE7
            end else if (conv_end && wrote_r && cfg_r.pm == `PM_AUTO) begin
               pwr_nxt = adc_ctrl_pkg::PWR_OFF; // RULE9
            end
         end
         adc_ctrl_pkg::PWR_WAKING: begin
            if (conv_end && cfg_r.pm == `PM_SHUTDOWN) begin
               pwr_nxt = adc_ctrl_pkg::PWR_OFF; // RULE7
            end else if (conv_end && wrote_r && cfg_r.pm == `PM_AUTO) begin
               pwr_nxt = adc_ctrl_pkg::PWR_OFF; // RULE9
            end else if (wake_r == '0) begin
               pwr_nxt = adc_ctrl_pkg::PWR_ON; // RULE10
            end else begin
               wake_nxt = WW'(wake_r - 1'b1); // RULE10
            end
         end
         adc_ctrl_pkg::PWR_OFF: begin
            // invalid 00 keeps the present state
            if (cfg_r.pm == `PM_NORMAL || (cfg_r.pm == `PM_AUTO && sif.cs_fall)) begin
               pwr_nxt = adc_ctrl_pkg::PWR_WAKING; // RULE6 RULE10
               wake_nxt = WW'(WAKE_M1);
            end
         end
         default: begin
            pwr_nxt = adc_ctrl_pkg::PWR_ON;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pwr_r <= adc_ctrl_pkg::PWR_ON;
         wake_r <= '0;
      end else begin
         pwr_r <= pwr_nxt;
         wake_r <= wake_nxt;
      end
   end

   assign DOUT = tx_r[15];
   assign DOUT_OE = sif.cs_active;
   assign MUX_CHANNEL = ch_r;
   assign SPAN_REF_ONLY = span_act_r;
   assign CODING_BINARY = coding_act_r;
   assign POWER_ON = (pwr_r == adc_ctrl_pkg::PWR_ON);
   assign WAKE_BUSY = (pwr_r == adc_ctrl_pkg::PWR_WAKING);
   assign SEQ_ACTIVE = seq_run_r;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_n);

   property p_write_loads;
      (ld_edge && word[`CW_WRITE]) |=> (cfg_r.coding == $past(sif.din)) && wrote_r;
   endproperty
   a_write_loads: assert property (p_write_loads) else $error("write bit did not load"); // RULE1

   property p_no_write_keeps;
      (ld_edge && !word[`CW_WRITE]) |=> $stable(cfg_r);
   endproperty
   a_no_write_keeps: assert property (p_no_write_keeps) else $error("register changed"); // RULE1

   property p_mux_edge_only;
      $changed(ch_r) |-> $past(mux_edge);
   endproperty
   a_mux_edge_only: assert property (p_mux_edge_only) else $error("mux moved off edge"); // RULE5

   property p_seq_start;
      (mux_edge && wrote_r && cfg_r.seq_hi && cfg_r.seq_lo) |=> (ch_r == 2'h0) && seq_run_r;
   endproperty
   a_seq_start: assert property (p_seq_start) else $error("sequence not at 0"); // RULE16

   property p_addr_first;
      sif.cs_fall |=> (tx_r[15:14] == $past(ch_r)) && (DOUT == $past(ch_r[1]));
   endproperty
   a_addr_first: assert property (p_addr_first) else $error("address bit not first"); // RULE4

   property p_coding;
      (sif.cs_fall && !cfg_r.coding) |=> tx_r[13] == !$past(CONV_RESULT[11]);
   endproperty
   a_coding: assert property (p_coding) else $error("twos complement wrong"); // RULE13

   property p_normal_stays;
      (cfg_r.pm == `PM_NORMAL && POWER_ON) |=> POWER_ON;
   endproperty
   a_normal_stays: assert property (p_normal_stays) else $error("left normal power"); // RULE6

   property p_shutdown_holds;
      (cfg_r.pm == `PM_SHUTDOWN && pwr_r == adc_ctrl_pkg::PWR_OFF) |=>
         pwr_r == adc_ctrl_pkg::PWR_OFF;
   endproperty
   a_shutdown_holds: assert property (p_shutdown_holds) else $error("woke in shutdown"); // RULE7

   property p_off_keeps_cfg;
      (pwr_r == adc_ctrl_pkg::PWR_OFF && !ld_edge) |=> $stable(cfg_r);
   endproperty
   a_off_keeps_cfg: assert property (p_off_keeps_cfg) else $error("config lost"); // RULE8

   property p_auto_off;
      (conv_end && wrote_r && cfg_r.pm == `PM_AUTO) |=> pwr_r == adc_ctrl_pkg::PWR_OFF;
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("auto shutdown missed"); // RULE9

   sequence s_wake_start;
      $rose(WAKE_BUSY);
   endsequence

   property p_wake_time;
      s_wake_start |-> !POWER_ON ##WAKE_M1 !POWER_ON;
   endproperty
   a_wake_time: assert property (p_wake_time) else $error("wake too short"); // RULE10
endmodule

// ### sim/serial_host_model.sv
`timescale 1ns/1ns
module serial_host_model (
   input wire logic clk, // bench clock
   input wire logic start, // begin one frame
   input wire logic [11:0] word, // control word to send
   input wire logic [3:0] junk, // filler after the word
   input wire logic [4:0] nfalls, // serial clock falls in frame
   input wire logic dout, // device data out
   input wire logic [1:0] mux, // device channel select
   output logic cs_b, // chip select, low active
   output logic sclk, // serial clock, idles high
   output logic din, // serial data to device
   output logic done, // frame finished, one cycle
   output logic [15:0] rx, // bits read in the frame
   output logic [1:0] mux14 // channel seen before fall 14
);
   task automatic frame();
      cs_b <= 1'b0;
      repeat (4) @(posedge clk);
      for (int k = 0; k < nfalls; k++) begin
         din <= (k < 12) ? word[11 - k] : junk[k % 4];
         repeat (4) @(posedge clk);
         rx[15 - k] <= dout;
         if (k == 13) mux14 <= mux;
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
      end
      repeat (8) @(posedge clk);
      cs_b <= 1'b1;
      done <= 1'b1;
   endtask

   initial begin
      cs_b = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
      done = 1'b0;
      rx = 16'h0000;
      mux14 = 2'h0;
      forever begin
         @(posedge clk);
         done <= 1'b0;
         // released data line toggles
         if (cs_b) din <= ~din;
         if (start) frame();
      end
   end
endmodule

// ### sim/adc_control_word_decoder_tb_top.sv
`timescale 1ns/1ns
`include "adc_ctrl_defs.svh"
module adc_control_word_decoder_tb_top;
   typedef struct {
      logic full;
      logic [15:0] rx;
      logic [1:0] m14;
      logic [7:0] st;
   } exp_s;
   logic clk, rst_b, cs_b, sclk, din, dout, dout_oe, span, coding, pwr, busy, seq_act;
   logic start, done;
   logic [11:0] conv, word;
   logic [1:0] mux, m14, ch;
   logic [3:0] junk;
   logic [4:0] nf;
   logic [15:0] rx;
   logic [31:0] rs = 32'h00002322;
   logic sq;
   logic [1:0] last;
   adc_ctrl_pkg::config_s cfg;
   exp_s q[$];
   exp_s e;
   int bad_count = 0;
   int samples_checked = 0;

   adc_control_word_decoder #(.WAKE_CYCLES(4)) adc_control_word_decoder_inst (
      .CLK(clk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .DIN(din),
      .CONV_RESULT(conv), .DOUT(dout), .DOUT_OE(dout_oe), .MUX_CHANNEL(mux),
      .SPAN_REF_ONLY(span), .CODING_BINARY(coding), .POWER_ON(pwr),
      .WAKE_BUSY(busy), .SEQ_ACTIVE(seq_act)
   );

   serial_host_model serial_host_model_inst (
      .clk(clk), .start(start), .word(word), .junk(junk), .nfalls(nf),
      .dout(dout), .mux(mux), .cs_b(cs_b), .sclk(sclk), .din(din),
      .done(done), .rx(rx), .mux14(m14)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task automatic report_and_stop();
      $display("compared %0d, mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic cmp_rx(input logic [17:0] got, input logic [17:0] want);
      samples_checked++;
      if (got !== want) begin
         bad_count++;
         $display("unexpected at %0t: readout %h want %h", $time, got, want);
      end
   endtask

   task automatic cmp_st(input logic [7:0] got, input logic [7:0] want);
      samples_checked++;
      if (got !== want) begin
         bad_count++;
         $display("unexpected at %0t: status %h want %h", $time, got, want);
      end
   endtask

   task automatic xfer(input logic [11:0] w, input logic [4:0] n);
      exp_s x;
      logic [31:0] r;
      logic wr;
      int t;
      @(posedge clk);
      r = rnd();
      conv <= r[11:0];
      junk <= r[15:12];
      word <= w;
      nf <= n;
      start <= 1'b1;
      wr = w[11] && n >= 5'hC;
      x.full = (n == 5'h10);
      x.rx = {ch, cfg.coding ? r[11:0] : {~r[11], r[10:0]}, 2'h0};
      x.m14 = ch;
      x.st[5:4] = {cfg.span, cfg.coding};
      if (wr) cfg = {w[10], w[7:6], w[5:4], w[3], w[1:0]};
      if (x.full) begin
         if (wr && w[10] && w[3]) begin
            sq = 1'b1;
            last = cfg.addr;
            ch = 2'h0;
         end else if (wr && !w[10]) begin
            sq = 1'b0;
            ch = cfg.addr;
         end else if (sq) begin
            ch = (ch == last) ? 2'h0 : ch + 2'h1;
         end else begin
            ch = cfg.addr;
         end
      end
      x.st[7:6] = ch;
      x.st[3] = !(cfg.pm == `PM_SHUTDOWN || (cfg.pm == `PM_AUTO && wr));
      x.st[2:0] = {1'b0, sq, 1'b1};
      q.push_back(x);
      @(posedge clk);
      start <= 1'b0;
      for (t = 0; t < 1000 && done !== 1'b1; t++) @(negedge clk);
      if (t >= 1000) begin
         bad_count++;
         $display("unexpected at %0t: frame never finished", $time);
         report_and_stop();
      end
      repeat (8) @(posedge clk);
   endtask

   always @(posedge clk) begin
      if (done === 1'b1) begin
         e = q.pop_front();
         if (e.full) cmp_rx({rx, m14}, {e.rx, e.m14});
         cmp_st({mux, span, coding, pwr, busy, seq_act, dout_oe}, e.st);
      end
   end

   initial begin
      logic [31:0] r;
      logic [11:0] w;
      logic [11:0] dir [12];
      dir = '{12'hFBF, 12'h000, 12'h000, 12'h000, 12'hCB0, 12'h000,
              12'h862, 12'h000, 12'h871, 12'h8D0, 12'h8D0, 12'h000};
      rst_b = 1'b0;
      start = 1'b0;
      word = 12'h000;
      junk = 4'h0;
      nf = 5'h10;
      conv = 12'h000;
      cfg = '0;
      cfg.pm = `CFG_RESET_PM;
      ch = 2'h0;
      sq = 1'b0;
      last = 2'h0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      cmp_st({mux, span, coding, pwr, busy, seq_act, dout_oe}, 8'h08);
      for (int i = 0; i < 12; i++) xfer(dir[i], 5'h10);
      xfer(12'h8F3, 5'h8);
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         w = r[11:0];
         if (w[5:4] == 2'h0) w[5:4] = `PM_NORMAL;
         if (w[10]) w[3] = 1'b1;
         xfer(w, (r[19:17] == 3'h0) ? 5'h8 : 5'h10);
      end
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule
